// ===== ipc_map.svh
// Constants for the idle and power-down controller.
`ifndef IPC_MAP_SVH
`define IPC_MAP_SVH
`define IPC_CTRL_IDLE_POS 0
`define IPC_CTRL_SLEEP_POS 1
`define IPC_CTRL_FLAG0_POS 2
`define IPC_CTRL_FLAG1_POS 3
`define IPC_CTRL_RESET 8'h00
`define IPC_RST_HOLD_OSC 24
`define IPC_KBD_WAKE_CLKS 1024
`endif

// ===== ipc_pkg.sv
// Types shared by the idle and power-down controller.
package ipc_pkg;
    typedef enum logic [2:0] {
        IPC_RUN = 3'b000,
        IPC_IDLE = 3'b001,
        IPC_SLEEP = 3'b010,
        IPC_SLEEP_WAKE = 3'b011,
        IPC_SLEEP_KBD = 3'b100
    } ipc_state_e;
    typedef logic [7:0] ipc_byte_t;
endpackage

// ===== ipc_cycle_count.sv
// Counter that reports when an input has stayed high for LIMIT cycles.
`timescale 1ns/1ps
module ipc_cycle_count #(
    parameter int LIMIT = 24
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic run,
    output logic done
);
    localparam int W = $clog2(LIMIT + 1);
    localparam logic [W-1:0] TOP = W'(LIMIT);
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (!run) begin
            next_count = '0;
        end else if (count != TOP) begin
            next_count = count + W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign done = run && (count == TOP);
endmodule

// ===== ipc_power_ctrl.sv
// Idle and power-down sequencing for the 8-bit controller core.
// How it works
// - Setting the idle bit finishes that write, then idle starts.
// - Idle stops the CPU clock; peripherals and interrupts keep running.
// - CPU state is frozen unchanged throughout idle.
// - Ports hold entry levels in idle, but with external memory port 0 floats and port 2 follows the core; both strobes are driven high.
// - Any enabled interrupt clears the idle bit and returns to running.
// - Two general flag bits are writable by software.
// - Reset held 24 oscillator periods ends idle and resets the core.
// - Power-down stops the oscillator after the requesting write.
// - RAM and special registers are retained through power-down.
// - Only external pins, keyboard or reset wake from power-down.
// - Keyboard wake waits 1024 clocks before running again.
// - A low pin restarts the oscillator; release completes the exit.
// - Either low pin restarts; first release exits; priority picks.
// - After an interrupt exit execution continues after the entry.
// - Reset exit reinitialises special registers; interrupt exit keeps.
// - With both bits set, power-down exit rules apply; both clear.
// - Strobes low in power-down; port 0 floats with external memory.
// - Holding port 0 drives only zeros and floats stored ones.
`timescale 1ns/1ps
`include "ipc_map.svh"
module ipc_power_ctrl #(
    parameter int RST_HOLD = `IPC_RST_HOLD_OSC,
    parameter int KBD_WAKE = `IPC_KBD_WAKE_CLKS
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ctrl_wr,
    input wire ipc_pkg::ipc_byte_t ctrl_wdata,
    output ipc_pkg::ipc_byte_t power_control_reg,
    input wire logic irq_pending,
    input wire logic [1:0] ext_int_en,
    input wire logic ext_int0_n,
    input wire logic external_interrupt_one_n,
    input wire logic kbd_irq,
    input wire logic reset_pin,
    input wire logic ext_prog_mem,
    input wire logic core_ale,
    input wire logic core_strobe,
    input wire ipc_pkg::ipc_byte_t core_p0_out,
    input wire ipc_pkg::ipc_byte_t core_p0_oe_n,
    input wire ipc_pkg::ipc_byte_t core_p2_out,
    input wire ipc_pkg::ipc_byte_t p0_latch,
    input wire ipc_pkg::ipc_byte_t p2_latch,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic osc_en,
    output logic ram_retain,
    output logic core_reset,
    output logic [1:0] wake_src,
    output logic ale,
    output logic program_store_strobe,
    output ipc_pkg::ipc_byte_t p0_out,
    output ipc_pkg::ipc_byte_t p0_oe_n,
    output ipc_pkg::ipc_byte_t p2_out
);
    import ipc_pkg::*;

    ipc_state_e state;
    ipc_state_e next_state;
    ipc_byte_t next_power_control_reg;
    logic [1:0] next_wake_src;
    logic [1:0] held_low;
    logic [1:0] next_held_low;
    logic next_ale;
    logic next_strobe;
    ipc_byte_t next_p0_out;
    ipc_byte_t next_p0_oe_n;
    ipc_byte_t next_p2_out;
    logic rst_done;
    logic kbd_done;
    logic [1:0] pin_low;
    logic [1:0] released;
    logic idle_bit;
    logic sleep_bit;

    function automatic logic is_halted(input ipc_state_e s);
        is_halted = (s != IPC_RUN);
    endfunction

    function automatic logic is_powerdown(input ipc_state_e s);
        is_powerdown = (s == IPC_SLEEP) || (s == IPC_SLEEP_WAKE)
            || (s == IPC_SLEEP_KBD);
    endfunction

    // Reset pin must stay high for two machine cycles before it acts.
    ipc_cycle_count #(.LIMIT(RST_HOLD)) u_rst_hold (
        .sys_clk(sys_clk),
        .reset(reset),
        .run(reset_pin),
        .done(rst_done)
    );

    ipc_cycle_count #(.LIMIT(KBD_WAKE)) u_kbd_wait (
        .sys_clk(sys_clk),
        .reset(reset),
        .run(state == IPC_SLEEP_KBD),
        .done(kbd_done)
    );

    assign idle_bit = power_control_reg[`IPC_CTRL_IDLE_POS];
    assign sleep_bit = power_control_reg[`IPC_CTRL_SLEEP_POS];
    assign pin_low = {~external_interrupt_one_n, ~ext_int0_n} & ext_int_en;
    assign released = held_low & ~pin_low;

    assign core_reset = rst_done;
    assign cpu_clk_en = !is_halted(state);
    assign periph_clk_en = osc_en;
    assign ram_retain = is_halted(state);
    // Oscillator restarts as soon as a wake source is present.
    assign osc_en = (state != IPC_SLEEP) || reset_pin
        || (|pin_low) || kbd_irq;

    always_comb begin
        next_state = state;
        next_power_control_reg = power_control_reg;
        next_wake_src = wake_src;
        next_held_low = held_low;
        case (state)
            IPC_RUN: begin
                if (ctrl_wr) begin
                    next_power_control_reg = ctrl_wdata;
                    if (ctrl_wdata[`IPC_CTRL_SLEEP_POS]) begin
                        next_state = IPC_SLEEP;
                    end else if (ctrl_wdata[`IPC_CTRL_IDLE_POS]) begin
                        next_state = IPC_IDLE;
                    end
                end
            end
            IPC_IDLE: begin
                if (irq_pending) begin
                    next_power_control_reg[`IPC_CTRL_IDLE_POS] = 1'b0;
                    next_state = IPC_RUN;
                end
            end
            IPC_SLEEP: begin
                if (|pin_low) begin
                    next_held_low = pin_low;
                    next_state = IPC_SLEEP_WAKE;
                end else if (kbd_irq) begin
                    next_state = IPC_SLEEP_KBD;
                end
            end
            IPC_SLEEP_WAKE: begin
                next_held_low = held_low | pin_low;
                if (|released) begin
                    next_wake_src = released[0] ? 2'h1 : 2'h2;
                    next_power_control_reg[`IPC_CTRL_IDLE_POS] = 1'b0;
                    next_power_control_reg[`IPC_CTRL_SLEEP_POS] = 1'b0;
                    next_held_low = 2'h0;
                    next_state = IPC_RUN;
                end
            end
            IPC_SLEEP_KBD: begin
                if (kbd_done) begin
                    next_wake_src = 2'h3;
                    next_power_control_reg[`IPC_CTRL_IDLE_POS] = 1'b0;
                    next_power_control_reg[`IPC_CTRL_SLEEP_POS] = 1'b0;
                    next_state = IPC_RUN;
                end
            end
            default: begin
                next_state = IPC_RUN;
            end
        endcase
        if (rst_done) begin
            next_state = IPC_RUN;
            next_power_control_reg = `IPC_CTRL_RESET;
            next_wake_src = 2'h0;
            next_held_low = 2'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= IPC_RUN;
            power_control_reg <= `IPC_CTRL_RESET;
            wake_src <= 2'h0;
            held_low <= 2'h0;
        end else begin
            state <= next_state;
            power_control_reg <= next_power_control_reg;
            wake_src <= next_wake_src;
            held_low <= next_held_low;
        end
    end

    // Pin drive follows the state the controller is entering.
    always_comb begin
        next_ale = core_ale;
        next_strobe = core_strobe;
        next_p0_out = core_p0_out;
        next_p0_oe_n = core_p0_oe_n;
        next_p2_out = core_p2_out;
        if (next_state == IPC_IDLE) begin
            next_ale = 1'b1;
            next_strobe = 1'b1;
            next_p2_out = ext_prog_mem ? core_p2_out : p2_latch;
        end else if (is_powerdown(next_state)) begin
            next_ale = 1'b0;
            next_strobe = 1'b0;
            next_p2_out = p2_latch;
        end
        if (is_halted(next_state)) begin
            next_p0_out = 8'h00;
            next_p0_oe_n = ext_prog_mem ? 8'hFF : p0_latch;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ale <= 1'b1;
            program_store_strobe <= 1'b1;
            p0_out <= 8'h00;
            p0_oe_n <= 8'hFF;
            p2_out <= 8'hFF;
        end else begin
            ale <= next_ale;
            program_store_strobe <= next_strobe;
            p0_out <= next_p0_out;
            p0_oe_n <= next_p0_oe_n;
            p2_out <= next_p2_out;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    chk_idle_entry_edge: assert property (
        state == IPC_RUN && ctrl_wr && ctrl_wdata[0] && !ctrl_wdata[1]
        && !rst_done |=> state == IPC_IDLE && !cpu_clk_en)
        else $error("Idle was not entered after the request write.");

    chk_powerdown_entry: assert property (
        state == IPC_RUN && ctrl_wr && ctrl_wdata[1] && !rst_done
        |=> state == IPC_SLEEP ##0 !cpu_clk_en)
        else $error("Power-down was not entered after the write.");

    chk_idle_clocks_split: assert property (
        state == IPC_IDLE |-> !cpu_clk_en && periph_clk_en && osc_en)
        else $error("Idle clock gating is wrong.");

    chk_idle_strobes_high: assert property (
        state == IPC_IDLE |-> ale && program_store_strobe)
        else $error("Strobes not high during idle.");

    chk_sleep_strobes_low: assert property (
        is_powerdown(state) |-> !ale && !program_store_strobe)
        else $error("Strobes not low during power-down.");

    chk_idle_irq_exit: assert property (
        state == IPC_IDLE && irq_pending
        |=> state == IPC_RUN && !idle_bit)
        else $error("Enabled interrupt did not end idle.");

    chk_osc_stopped_sleep: assert property (
        state == IPC_SLEEP && !reset_pin && pin_low == 2'h0 && !kbd_irq
        |-> !osc_en)
        else $error("Oscillator running in quiet power-down.");

    chk_kbd_wait_hold: assert property (
        state == IPC_SLEEP_KBD && !kbd_done && !rst_done
        |=> state == IPC_SLEEP_KBD)
        else $error("Keyboard wake left before its delay.");

    chk_pin_release_exit: assert property (
        state == IPC_SLEEP_WAKE && (|released) && !rst_done
        |=> state == IPC_RUN && !idle_bit && !sleep_bit)
        else $error("Pin release did not complete power-down exit.");

    chk_p0_drive_zero: assert property (
        is_halted(state) |-> (p0_oe_n | ~p0_out) == 8'hFF)
        else $error("Port 0 drove a one while holding.");

    chk_reset_short_pulse: assert property (
        $rose(reset_pin) ##1 reset_pin [*8] |-> !core_reset)
        else $error("Reset acted before its hold time.");

    chk_flags_kept_halted: assert property (
        state == IPC_IDLE && !irq_pending && !rst_done
        |=> $stable(power_control_reg))
        else $error("Power control register changed during idle.");
endmodule

// ===== ipc_wake_model.sv
// Wake-source model for the far side of the power controller.
`timescale 1ns/1ps
module ipc_wake_model (
    input wire logic sys_clk,
    input wire logic [2:0] go,
    input wire logic [7:0] hold0,
    input wire logic [7:0] hold1,
    output logic ext_int0_n,
    output logic external_interrupt_one_n,
    output logic kbd_irq
);
    logic [7:0] cnt0 = 8'h00;
    logic [7:0] cnt1 = 8'h00;
    initial kbd_irq = 1'b0;
    // A wake pin is held low for the whole hold time, long enough to restart.
    always @(posedge sys_clk) begin
        cnt0 <= go[0] ? hold0 : (cnt0 != 8'h00 ? cnt0 - 8'h01 : 8'h00);
        cnt1 <= go[1] ? hold1 : (cnt1 != 8'h00 ? cnt1 - 8'h01 : 8'h00);
        kbd_irq <= go[2];
    end
    // Released pins return to the pull-up level.
    assign ext_int0_n = (cnt0 == 8'h00);
    assign external_interrupt_one_n = (cnt1 == 8'h00);
endmodule

// ===== ipc_power_ctrl_tb.sv
// Self-checking bench for the idle and power-down controller.
`timescale 1ns/1ps
module ipc_power_ctrl_tb;
    import ipc_pkg::*;
    localparam int RH = 4;
    localparam int KW = 16;
    typedef struct {string name; ipc_byte_t exp;} ipc_note_s;
    ipc_note_s notes[$];
    ipc_note_s nt;
    int errors = 0;
    int checks = 0;
    logic [31:0] seed = 32'h35DF;
    logic sys_clk = 1'b0;
    logic reset, ctrl_wr, irq_pending, reset_pin, ext_prog_mem;
    logic core_ale, core_strobe, ext_int0_n, external_interrupt_one_n;
    logic kbd_irq, cpu_clk_en, periph_clk_en, osc_en, ram_retain;
    logic core_reset, ale, program_store_strobe;
    ipc_byte_t ctrl_wdata, power_control_reg, core_p0_out, core_p0_oe_n;
    ipc_byte_t core_p2_out, p0_latch, p2_latch, p0_out, p0_oe_n, p2_out;
    logic [1:0] ext_int_en, wake_src;
    logic [2:0] go;
    logic [7:0] hold0, hold1;

    ipc_power_ctrl #(.RST_HOLD(RH), .KBD_WAKE(KW)) ipc_power_ctrl_inst (
        .sys_clk, .reset, .ctrl_wr, .ctrl_wdata, .power_control_reg,
        .irq_pending, .ext_int_en, .ext_int0_n, .external_interrupt_one_n,
        .kbd_irq, .reset_pin, .ext_prog_mem, .core_ale, .core_strobe,
        .core_p0_out, .core_p0_oe_n, .core_p2_out, .p0_latch, .p2_latch,
        .cpu_clk_en, .periph_clk_en, .osc_en, .ram_retain, .core_reset,
        .wake_src, .ale, .program_store_strobe, .p0_out, .p0_oe_n, .p2_out);
    ipc_wake_model ipc_wake_model_inst (.sys_clk, .go, .hold0, .hold1,
        .ext_int0_n, .external_interrupt_one_n, .kbd_irq);

    initial forever #25 sys_clk = ~sys_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic ipc_byte_t seen(input string n);
        case (n)
            "reg": return power_control_reg;
            "clk": return {7'h00, cpu_clk_en};
            "osc": return {7'h00, osc_en};
            "per": return {7'h00, periph_clk_en};
            "ram": return {7'h00, ram_retain};
            "rst": return {7'h00, core_reset};
            "stb": return {6'h00, ale, program_store_strobe};
            "src": return {6'h00, wake_src};
            "p0": return p0_out;
            "p0e": return p0_oe_n;
            default: return p2_out;
        endcase
    endfunction

    task automatic note(input string n, input ipc_byte_t e);
        notes.push_back('{n, e});
    endtask

    task automatic check_val(input string n, input ipc_byte_t e,
                             input ipc_byte_t s);
        checks++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    // The watcher compares every pending note once the outputs settle.
    always @(negedge sys_clk) begin
        while (notes.size() > 0) begin
            nt = notes.pop_front();
            check_val(nt.name, nt.exp, seen(nt.name));
        end
    end

    task automatic print_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wr(input ipc_byte_t d);
        ctrl_wr <= 1'b1;
        ctrl_wdata <= d;
        @(posedge sys_clk);
        ctrl_wr <= 1'b0;
    endtask

    task automatic pulse(input logic [2:0] g, input int h0, input int h1);
        go <= g;
        hold0 <= h0[7:0];
        hold1 <= h1[7:0];
        @(posedge sys_clk);
        go <= 3'b000;
    endtask

    task automatic rnd_ports;
        seed = lfsr(seed);
        p0_latch <= seed[7:0];
        p2_latch <= seed[15:8];
        core_p2_out <= seed[23:16];
        core_p0_out <= seed[31:24];
        core_p0_oe_n <= seed[23:16];
        core_ale <= seed[0];
        core_strobe <= seed[1];
    endtask

    // Waits, bounded, for the CPU clock to come back.
    task automatic wait_run(input int lim);
        int n;
        n = 0;
        while (n < lim) begin
            @(negedge sys_clk);
            if (cpu_clk_en === 1'b1)
                break;
            n++;
        end
        @(posedge sys_clk);
        if (n == lim) begin
            errors++;
            $display("unexpected wake expected run seen stopped");
            print_verdict();
        end
    endtask

    initial begin
        reset <= 1'b1;
        ctrl_wr <= 1'b0;
        ctrl_wdata <= 8'h00;
        irq_pending <= 1'b0;
        ext_int_en <= 2'b11;
        reset_pin <= 1'b0;
        ext_prog_mem <= 1'b0;
        go <= 3'b000;
        hold0 <= 8'h00;
        hold1 <= 8'h00;
        rnd_ports();
        tick(12);
        reset <= 1'b0;
        tick(1);
        note("reg", 8'h00);
        note("stb", {6'h00, core_ale, core_strobe});
        note("p0e", core_p0_oe_n);
        note("src", 8'h00);
        $display("test reset done");
        for (int m = 0; m < 2; m++) begin
            ext_prog_mem <= m[0];
            rnd_ports();
            wr(8'h0D);
            note("clk", 8'h00);
            note("per", 8'h01);
            note("stb", 8'h03);
            note("reg", 8'h0D);
            note("p0", 8'h00);
            note("p0e", m[0] ? 8'hFF : p0_latch);
            note("p2", m[0] ? core_p2_out : p2_latch);
            tick(1);
            wr(8'hF0);
            note("reg", 8'h0D);
            irq_pending <= 1'b1;
            tick(1);
            irq_pending <= 1'b0;
            note("clk", 8'h01);
            note("reg", 8'h0C);
            $display("test idle %0d done", m);
        end
        rnd_ports();
        wr(8'h02);
        note("osc", 8'h00);
        note("clk", 8'h00);
        note("stb", 8'h00);
        note("ram", 8'h01);
        note("p0e", 8'hFF);
        note("p2", p2_latch);
        ext_int_en <= 2'b10;
        irq_pending <= 1'b1;
        pulse(3'b001, 4, 0);
        irq_pending <= 1'b0;
        tick(6);
        note("osc", 8'h00);
        ext_int_en <= 2'b11;
        pulse(3'b001, 10, 0);
        tick(2);
        note("osc", 8'h01);
        note("clk", 8'h00);
        wait_run(20);
        note("reg", 8'h00);
        note("src", 8'h01);
        wr(8'h03);
        pulse(3'b011, 12, 6);
        wait_run(30);
        note("src", 8'h02);
        note("reg", 8'h00);
        tick(12);
        $display("test pin wake done");
        wr(8'h02);
        pulse(3'b100, 0, 0);
        tick(KW);
        note("clk", 8'h00);
        wait_run(20);
        note("src", 8'h03);
        $display("test keyboard wake done");
        wr(8'h01);
        reset_pin <= 1'b1;
        tick(RH - 1);
        note("rst", 8'h00);
        tick(1);
        note("rst", 8'h01);
        tick(1);
        note("reg", 8'h00);
        note("clk", 8'h01);
        note("src", 8'h00);
        reset_pin <= 1'b0;
        $display("test reset pin done");
        @(negedge sys_clk);
        @(negedge sys_clk);
        print_verdict();
    end
endmodule
